// file: pkg/ccpc_pkg.sv
// Package for the core clock and power control block.
package ccpc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] CCPC_SRC_KEY1_OFF  = 8'h00;
  localparam logic [7:0] CCPC_SRC_CTRL_OFF  = 8'h04;
  localparam logic [7:0] CCPC_SRC_KEY2_OFF  = 8'h08;
  localparam logic [7:0] CCPC_PWR_KEY1_OFF  = 8'h0c;
  localparam logic [7:0] CCPC_PWR_CTRL_OFF  = 8'h10;
  localparam logic [7:0] CCPC_PWR_KEY2_OFF  = 8'h14;
  localparam logic [7:0] CCPC_STATUS_OFF    = 8'h18;
  // ==========================================================================
  // Keys
  localparam logic [7:0] CCPC_SRC_KEY1_VAL  = 8'haa;
  localparam logic [7:0] CCPC_SRC_KEY2_VAL  = 8'h55;
  localparam logic [7:0] CCPC_PWR_KEY1_VAL  = 8'h01;
  localparam logic [7:0] CCPC_PWR_KEY2_VAL  = 8'hf4;
  // ==========================================================================
  // Fields and reset values
  localparam logic [7:0] CCPC_SRC_RESET     = 8'h01;
  localparam logic [7:0] CCPC_PWR_RESET     = 8'h03;
  localparam logic [7:0] CCPC_SRC_MASK      = 8'h07;
  localparam logic [7:0] CCPC_PWR_MASK      = 8'h7f;
  localparam logic [1:0] CCPC_MODE_PLL      = 2'h1;
  localparam logic [1:0] CCPC_MODE_EXT      = 2'h3;
  localparam logic [2:0] CCPC_OP_NORMAL     = 3'h0;
  localparam logic [2:0] CCPC_OP_PDOWN      = 3'h3;
  localparam int         CCPC_PLL_MULT      = 1376;
  localparam logic [6:0] CCPC_DIV_MAX       = 7'h7f;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       wdog_int_osc;
    logic [1:0] clock_mode_select;
  } ccpc_src_t;

  typedef struct packed {
    logic       rsvd;
    logic [2:0] operating_mode_field;
    logic       fast_interrupt_boost;
    logic [2:0] core_divider;
  } ccpc_pwr_t;

  typedef enum logic [3:0] {
    CCPC_IDLE  = 4'b0001,
    CCPC_GOT_K = 4'b0010,
    CCPC_GOT_V = 4'b0100,
    CCPC_DONE  = 4'b1000
  } ccpc_unlock_t;
endpackage : ccpc_pkg

// file: design/ccpc_top.sv
// Core clock divider, source select and power control with APB registers.
// How it works
// (RULE_01) System clock is the PLL clock, 1376 times the 32.768 kHz oscillator.
// (RULE_02) Reset leaves the divider at three, core runs at PLL divided by eight.
// (RULE_03) Divider field bits 2..0 divide the PLL clock by two to that power.
// (RULE_04) Current core clock is driven out on a dedicated output pin; undivided, the pin toggles at half the core rate.
// (RULE_05) Software writes 0xaa, new source value, then 0x55 to change source.
// (RULE_06) Software writes 0x01, new power value, then 0xf4 to change power.
// (RULE_07) Bit 2 of source register picks internal oscillator for watchdog.
// (RULE_08) Mode bits 1..0: 01 PLL with oscillator, 11 external clock pin.
// (RULE_09) Mode 000 normal, 011 power-down woken by two IRQs and two timers.
// (RULE_10) Fast interrupt bit runs core undivided while an interrupt is served.
// (RULE_11) Protected writes count only as three consecutive writes in order.
//
// Register access over APB and the register offsets are this design's own decisions.
module ccpc_top
  import ccpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_active,
  input  wire logic        external_interrupt_zero,
  input  wire logic        external_interrupt_one,
  input  wire logic        timer2_wake,
  input  wire logic        timer3_wake,
  output logic             core_clock_out_pin,
  output logic             core_clk_en,
  output logic             use_external_clock_in_pin,
  output logic             watchdog_slow_clock_select,
  output logic             powered_down
);
  // ==========================================================================
  // Bus decode
  logic       wr_acc;
  logic [7:0] wbyte;
  assign wr_acc = psel & penable & pwrite;
  assign wbyte  = pwdata[7:0];

  // ==========================================================================
  // Unlock sequencers
  ccpc_unlock_t src_st_ff, nxt_src_st, pwr_st_ff, nxt_pwr_st;
  ccpc_src_t    src_ff, nxt_src, src_pend_ff, nxt_src_pend;
  ccpc_pwr_t    pwr_ff, nxt_pwr, pwr_pend_ff, nxt_pwr_pend;

  function automatic ccpc_unlock_t step(
    input ccpc_unlock_t st,
    input logic [7:0]   addr,
    input logic [7:0]   data,
    input logic [7:0]   k1_off,
    input logic [7:0]   v_off,
    input logic [7:0]   k2_off,
    input logic [7:0]   k1,
    input logic [7:0]   k2
  );
    ccpc_unlock_t n;
    n = CCPC_IDLE;
    if (addr == k1_off && data == k1) begin
      n = CCPC_GOT_K;
    end else if (st == CCPC_GOT_K && addr == v_off) begin
      n = CCPC_GOT_V;
    end else if (st == CCPC_GOT_V && addr == k2_off && data == k2) begin
      n = CCPC_DONE;
    end
    return n;
  endfunction : step

  logic in_pdown;
  logic wake;
  assign wake = external_interrupt_zero | external_interrupt_one |
                timer2_wake | timer3_wake;

  always_comb begin
    nxt_src_st   = src_st_ff;
    nxt_pwr_st   = pwr_st_ff;
    nxt_src      = src_ff;
    nxt_pwr      = pwr_ff;
    nxt_src_pend = src_pend_ff;
    nxt_pwr_pend = pwr_pend_ff;
    if (src_st_ff == CCPC_DONE) begin
      nxt_src_st = CCPC_IDLE;
    end
    if (pwr_st_ff == CCPC_DONE) begin
      nxt_pwr_st = CCPC_IDLE;
    end
    if (wr_acc) begin
      // (RULE_11) Consecutive key order
      nxt_src_st = step(src_st_ff, paddr, wbyte, CCPC_SRC_KEY1_OFF,
                        CCPC_SRC_CTRL_OFF, CCPC_SRC_KEY2_OFF,
                        CCPC_SRC_KEY1_VAL, CCPC_SRC_KEY2_VAL);
      nxt_pwr_st = step(pwr_st_ff, paddr, wbyte, CCPC_PWR_KEY1_OFF,
                        CCPC_PWR_CTRL_OFF, CCPC_PWR_KEY2_OFF,
                        CCPC_PWR_KEY1_VAL, CCPC_PWR_KEY2_VAL);
      if (src_st_ff == CCPC_GOT_K && paddr == CCPC_SRC_CTRL_OFF) begin
        nxt_src_pend = ccpc_src_t'(wbyte & CCPC_SRC_MASK);
      end
      if (pwr_st_ff == CCPC_GOT_K && paddr == CCPC_PWR_CTRL_OFF) begin
        nxt_pwr_pend = ccpc_pwr_t'(wbyte & CCPC_PWR_MASK);
      end
      // (RULE_05) Source commit on key two
      if (nxt_src_st == CCPC_DONE) begin
        nxt_src = src_pend_ff;
      end
      // (RULE_06) Power commit on key two
      if (nxt_pwr_st == CCPC_DONE) begin
        nxt_pwr = pwr_pend_ff;
      end
    end
    // (RULE_09) Wake sources end power-down
    if (in_pdown && wake) begin
      nxt_pwr.operating_mode_field = CCPC_OP_NORMAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_st_ff   <= CCPC_IDLE;
      pwr_st_ff   <= CCPC_IDLE;
      // (RULE_02) Reset divide by eight
      src_ff      <= ccpc_src_t'(CCPC_SRC_RESET);
      pwr_ff      <= ccpc_pwr_t'(CCPC_PWR_RESET);
      src_pend_ff <= ccpc_src_t'(CCPC_SRC_RESET);
      pwr_pend_ff <= ccpc_pwr_t'(CCPC_PWR_RESET);
    end else begin
      src_st_ff   <= nxt_src_st;
      pwr_st_ff   <= nxt_pwr_st;
      src_ff      <= nxt_src;
      pwr_ff      <= nxt_pwr;
      src_pend_ff <= nxt_src_pend;
      pwr_pend_ff <= nxt_pwr_pend;
    end
  end

  assign in_pdown = (pwr_ff.operating_mode_field == CCPC_OP_PDOWN);

  // ==========================================================================
  // Divider. Pclk stands in for the PLL output; the core is gated by an
  // enable pulse because a derived clock would need its own domain.
  logic [6:0] div_cnt_ff, nxt_div_cnt;
  logic [6:0] div_lim;
  logic       en_ff, nxt_en, clk_out_ff, nxt_clk_out;
  logic [2:0] div_sel;

  // (RULE_10) Undivided while interrupt served
  assign div_sel = (pwr_ff.fast_interrupt_boost && irq_active) ?
                   3'h0 : pwr_ff.core_divider;
  // (RULE_03) Divide by two to the field
  assign div_lim = CCPC_DIV_MAX >> (3'h7 - div_sel);

  always_comb begin
    nxt_div_cnt = div_cnt_ff + 7'h01;
    nxt_en      = 1'b0;
    nxt_clk_out = clk_out_ff;
    if (div_cnt_ff >= div_lim) begin
      nxt_div_cnt = 7'h00;
      nxt_en      = 1'b1;
    end
    // (RULE_04) Clock out follows core rate, except undivided where it runs at half rate
    if (div_sel == 3'h0) begin
      nxt_clk_out = ~clk_out_ff;
    end else if (div_cnt_ff == div_lim || div_cnt_ff == (div_lim >> 1)) begin
      nxt_clk_out = (div_cnt_ff == div_lim);
    end
    if (in_pdown) begin
      nxt_en      = 1'b0;
      nxt_clk_out = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 7'h00;
      en_ff      <= 1'b0;
      clk_out_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      en_ff      <= nxt_en;
      clk_out_ff <= nxt_clk_out;
    end
  end

  // ==========================================================================
  // Outputs and read back
  logic [31:0] rd_ff, nxt_rd;
  logic        err_ff, nxt_err, rdy_ff, nxt_rdy;
  logic        ext_ff, wd_ff, pd_ff;

  always_comb begin
    nxt_rd  = 32'h0000_0000;
    nxt_err = 1'b0;
    nxt_rdy = psel & ~penable;
    unique case (paddr)
      CCPC_SRC_CTRL_OFF: nxt_rd = {24'h000000, src_ff};
      CCPC_PWR_CTRL_OFF: nxt_rd = {24'h000000, pwr_ff};
      CCPC_STATUS_OFF:   nxt_rd = {28'h0000000, src_st_ff};
      CCPC_SRC_KEY1_OFF, CCPC_SRC_KEY2_OFF,
      CCPC_PWR_KEY1_OFF, CCPC_PWR_KEY2_OFF: nxt_rd = 32'h0000_0000;
      default:           nxt_err = psel & ~penable;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ff  <= 32'h0000_0000;
      err_ff <= 1'b0;
      rdy_ff <= 1'b0;
      ext_ff <= 1'b0;
      wd_ff  <= 1'b0;
      pd_ff  <= 1'b0;
    end else begin
      rd_ff  <= nxt_rd;
      err_ff <= nxt_err;
      rdy_ff <= nxt_rdy;
      // (RULE_08) External clock mode
      ext_ff <= (src_ff.clock_mode_select == CCPC_MODE_EXT);
      // (RULE_07) Watchdog slow clock choice
      wd_ff  <= src_ff.wdog_int_osc;
      pd_ff  <= in_pdown;
    end
  end

  // (RULE_01) PLL ratio is an analog fact; pclk is its 1376x output.
  assign prdata                     = rd_ff;
  assign pready                     = rdy_ff;
  assign pslverr                    = err_ff;
  assign core_clk_en                = en_ff;
  assign core_clock_out_pin         = clk_out_ff;
  assign use_external_clock_in_pin  = ext_ff;
  assign watchdog_slow_clock_select = wd_ff;
  assign powered_down               = pd_ff;
endmodule : ccpc_top

// file: verif/ccpc_props.sv
// Checker properties for the core clock and power control block.
module ccpc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_interrupt_zero,
  input wire logic        core_clk_en,
  input wire logic        use_external_clock_in_pin,
  input wire logic        powered_down
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Bus access steps
  sequence setup_s; psel && !penable; endsequence
  sequence done_s; psel && penable && pready; endsequence
  ready_after_setup_a:
    assert property (setup_s |=> pready) else $error("ready missing");
  ready_single_a:
    assert property (pready |=> !pready) else $error("ready too long");
  ready_in_access_a:
    assert property (pready |-> psel && penable) else $error("stray ready");
  unmapped_error_a:
    assert property ((done_s and (paddr > 8'h18)) |-> pslverr)
      else $error("no error flag");
  mapped_no_error_a:
    assert property ((done_s and (paddr <= 8'h18 && paddr[1:0] == 2'h0))
      |-> !pslverr) else $error("false error flag");
  key_reads_zero_a:
    assert property ((done_s and (!pwrite && paddr == 8'h00))
      |-> prdata == 0) else $error("key reads nonzero");
  reset_outputs_a:
    assert property ($rose(presetn) |-> !powered_down
      && !use_external_clock_in_pin) else $error("bad reset outputs");
  pdown_no_clock_a:
    assert property (powered_down && $past(powered_down) |-> !core_clk_en)
      else $error("core clock in power down");
  wake_exit_a:
    assert property (powered_down && external_interrupt_zero
      |-> ##[1:3] !powered_down) else $error("no wake");
endmodule : ccpc_props

bind ccpc_top ccpc_props chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .external_interrupt_zero(external_interrupt_zero),
  .core_clk_en(core_clk_en),
  .use_external_clock_in_pin(use_external_clock_in_pin),
  .powered_down(powered_down));

// file: verif/ccpc_top_tb.sv
// Self-checking testbench for the core clock and power control block.
module ccpc_top_tb import ccpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  wk = 0;
  logic        pready, pslverr, err, clk_en, ext, wd, pd, co;
  int          mismatches = 0, cmp_count = 0, p;
  always #5 pclk = ~pclk;
  ccpc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_active(irq),
    .external_interrupt_zero(wk[0]), .external_interrupt_one(wk[1]),
    .timer2_wake(wk[2]), .timer3_wake(wk[3]), .core_clock_out_pin(co),
    .core_clk_en(clk_en), .use_external_clock_in_pin(ext),
    .watchdog_slow_clock_select(wd), .powered_down(pd));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Request is held until ready is sampled high, then penable drops.
  // The wait has no limit of its own; the watchdog ends a hung access.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 0;
  endtask : apb
  task automatic idle(input int n);
    psel <= 0;
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic wr3(input logic [7:0] b, v, k1, k2);
    apb(1, b, k1);
    apb(1, b + 8'h04, v);
    apb(1, b + 8'h08, k2);
    idle(3);
  endtask : wr3
  // Counts pclk cycles between two core clock enable pulses.
  task automatic per(output int q);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (clk_en !== 1 && n < 300);
    q = 0;
    do begin @(posedge pclk); q++; end while (clk_en !== 1 && q < 300);
  endtask : per
  // Counts rising edges of the clock out pin over 32 pclk cycles.
  task automatic rises(output int q);
    logic prev;
    q = 0;
    prev = co;
    repeat (32) begin
      @(posedge pclk);
      if (co === 1'b1 && prev === 1'b0) q++;
      prev = co;
    end
  endtask : rises
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // ==========================================================================
  // Watchdog
  initial begin
    #300000;
    mismatches++;
    summarize();
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h04, 0); chk(rd, 32'h1);
    apb(0, 8'h10, 0); chk(rd, 32'h3);
    idle(1);
    per(p); chk(p, 8);
    rises(p); chk(p, 4);
    wr3(8'h00, 8'hff, 8'haa, 8'h55);
    apb(0, 8'h04, 0); chk(rd, 32'h7);
    chk({ext, wd}, 2'b11);
    apb(1, 8'h04, 8'h01);
    apb(0, 8'h04, 0); chk(rd, 32'h7);
    apb(1, 8'h00, 8'haa);
    apb(1, 8'h04, 8'h01);
    apb(1, 8'h0c, 8'h01);
    apb(1, 8'h08, 8'h55);
    apb(0, 8'h04, 0); chk(rd, 32'h7);
    apb(1, 8'h00, 8'haa);
    apb(1, 8'h04, 8'h05);
    apb(0, 8'h00, 0);
    apb(1, 8'h08, 8'h55);
    apb(0, 8'h04, 0); chk(rd, 32'h5);
    apb(0, 8'h1c, 0); chk(err, 1);
    idle(2);
    chk({ext, wd}, 2'b01);
    wr3(8'h00, 8'h01, 8'haa, 8'h55);
    chk({ext, wd}, 2'b00);
    for (int i = 0; i < 8; i++) begin
      wr3(8'h0c, i[7:0], 8'h01, 8'hf4);
      per(p); chk(p, 1 << i);
      if (i > 0 && i < 6) rises(p);
      if (i > 0 && i < 6) chk(p, 32 >> i);
    end
    wr3(8'h0c, 8'h0b, 8'h01, 8'hf4);
    irq <= 1;
    idle(2);
    per(p); chk(p, 1);
    irq <= 0;
    per(p);
    per(p); chk(p, 8);
    for (int i = 0; i < 4; i++) begin
      wr3(8'h0c, 8'h30, 8'h01, 8'hf4);
      chk(pd, 1);
      rises(p); chk(p, 0);
      wk[i] <= 1;
      idle(3);
      chk(pd, 0);
      wk <= 0;
      apb(0, 8'h10, 0); chk(rd[6:4], 0);
      idle(1);
    end
    summarize();
  end
endmodule : ccpc_top_tb
